// [verilog/lcm_map.svh]
// Offsets, field positions and reset values for the legacy mode gating block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef LCM_MAP_SVH
`define LCM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCM_REG_MODE      8'h00
`define LCM_REG_FEAT_REQ  8'h01
`define LCM_REG_FEAT_EFF  8'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCM_MODE_COMPAT   0
`define LCM_MODE_LATCHED  1
`define LCM_FEAT_USART1   0
`define LCM_FEAT_TIMER3   1
`define LCM_FEAT_OCRC     2
`define LCM_FEAT_TWI      3
`define LCM_FEAT_BOOT     4
`define LCM_FEAT_WIDTH    5
`define LCM_FEAT_RESET    5'h1F

// ----------------------------------------
// Data space map
// ----------------------------------------
`define LCM_IO_COUNT      16'h0040
`define LCM_DS_IO_BASE    16'h0020
`define LCM_EXT_IO_BASE   16'h0060
`define LCM_EXT_IO_LAST   16'h00FF
`define LCM_RAM_BASE_NEW  16'h0100
`define LCM_RAM_BASE_OLD  16'h0060

// ----------------------------------------
// Gating values
// ----------------------------------------
`define LCM_BAUD_LOW_MASK 12'h0FF
`define LCM_RSTF_KEEP     5'h03
`define LCM_SENSE_LEVEL   8'h00
`define LCM_PORTC_ALL_OUT 8'hFF
`define LCM_PORTF_ALL_IN  8'h00
`define LCM_RXBUF_NATIVE  2'h2
`define LCM_RXBUF_COMPAT  2'h1

`endif

// [verilog/lcm_pkg.sv]
// Types shared by the legacy mode gating block.
// Assumes lcm_map.svh is on the include path.
package lcm_pkg;

    `include "lcm_map.svh"

    // ----------------------------------------
    // Mode latch states
    // ----------------------------------------
    typedef enum logic [1:0] {
        LCM_ST_WAIT   = 2'b00,
        LCM_ST_NATIVE = 2'b01,
        LCM_ST_COMPAT = 2'b10
    } lcm_mode_t;

    // ----------------------------------------
    // CPU data access and its decode
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic        io_instr;
    } lcm_acc_t;

    typedef struct packed {
        logic        io;
        logic        ext_io;
        logic        ram;
        logic [5:0]  io_addr;
        logic [15:0] ram_off;
    } lcm_sel_t;

    // ----------------------------------------
    // Peripheral requests and gated controls
    // ----------------------------------------
    typedef struct packed {
        logic        usart_sync;
        logic [11:0] baud_div;
        logic [7:0]  portc_dir;
        logic [7:0]  portf_dir;
        logic        portg_gpio;
        logic [7:0]  int_sense;
        logic        trim_wr;
        logic        wdt_chg;
        logic        wdt_unlock;
        logic [4:0]  rst_cause;
        logic        ws_split;
        logic [2:0]  xmem_release;
    } lcm_req_t;

    typedef struct packed {
        logic        usart_sync;
        logic [11:0] baud_div;
        logic [7:0]  portc_dir;
        logic        portc_in_en;
        logic [7:0]  portf_dir;
        logic        portg_gpio;
        logic [7:0]  int_sense;
        logic        trim_wr;
        logic        wdt_chg;
        logic [4:0]  mcu_control_status_reg;
        logic        ws_split;
        logic [2:0]  xmem_release;
        logic [1:0]  rx_buf_depth;
        logic        ext_vectors;
    } lcm_ctl_t;

    typedef struct packed {
        logic usart1;
        logic timer3;
        logic ocr_c;
        logic twi;
        logic boot;
        logic ext_io;
    } lcm_unit_en_t;

endpackage : lcm_pkg

// [verilog/lcm_gate.sv]
// Legacy compatibility mode gating: latches the fuse, decodes data space,
// and masks newer features when the old layout is selected.
// Assumes peripherals apply the gated controls and the fuse is static.
//
// Functional notes
// [R01] Extended I/O occupies data addresses 0x60 to 0xFF.
// [R02] The 64 legacy I/O locations keep their old addresses.
// [R03] Extended I/O answers only load/store, never short I/O instructions.
// [R04] Compat mode disables extended I/O and puts RAM at old addresses.
// [R05] Compat mode drops extended interrupt vectors.
// [R06] Compat: one USART, async only, low eight baud bits.
// [R07] Compat: one 16-bit timer with two compare registers.
// [R08] Compat: two-wire interface unavailable.
// [R09] Compat: port C output only.
// [R10] Compat: port G alternate functions only.
// [R11] Compat: port F digital input only.
// [R12] Compat: boot loader disabled.
// [R13] Compat: oscillator trim writes blocked.
// [R14] Compat: no address pin release, no split wait states.
// [R15] Compat: only external and power-on reset flags exist.
// [R16] Compat: watchdog time-out change needs no timed sequence.
// [R17] Compat: external interrupts 3..0 level sensed only.
// [R18] Compat: receiver has no FIFO, so overrun comes earlier.
// [R19] Software writes zero to bits the old device left unused.
// [R20] Fuse latched at reset release, then held static.
`timescale 1ns/1ps

module lcm_gate
    import lcm_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Fuse, high when programmed
    input  wire logic         legacy_compat_fuse,
    // Register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [7:0]   reg_rdata,
    // CPU data access
    input  wire lcm_acc_t     cpu_acc,
    output lcm_sel_t          cpu_sel,
    // Peripheral controls
    input  wire lcm_req_t     periph_req,
    output lcm_ctl_t          periph_ctl,
    output lcm_unit_en_t      unit_en
);

    `include "lcm_map.svh"

    // ----------------------------------------
    // Mode latch
    // ----------------------------------------
    lcm_mode_t                    mode;
    logic                         compat;
    logic [`LCM_FEAT_WIDTH-1:0]   feat_req;
    logic [`LCM_FEAT_WIDTH-1:0]   feat_eff;
    lcm_sel_t                     next_sel;

    // Reset value is a constant; the fuse is sampled on the first edge after release.
    // [R20] latch fuse once
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode <= LCM_ST_WAIT;
        end else begin
            unique case (mode)
                LCM_ST_WAIT: begin
                    mode <= legacy_compat_fuse ? LCM_ST_COMPAT : LCM_ST_NATIVE;
                end
                LCM_ST_NATIVE: begin
                    mode <= LCM_ST_NATIVE;
                end
                LCM_ST_COMPAT: begin
                    mode <= LCM_ST_COMPAT;
                end
                default: begin
                    mode <= LCM_ST_WAIT;
                end
            endcase
        end
    end

    // Until the fuse is caught, behave as the old part: safest default.
    assign compat = (mode != LCM_ST_NATIVE);

    // ----------------------------------------
    // Data space decode
    // ----------------------------------------
    function automatic lcm_sel_t decode(input lcm_acc_t acc, input logic old_map);
        lcm_sel_t   s;
        logic [15:0] ram_base;
        s        = '0;
        ram_base = old_map ? `LCM_RAM_BASE_OLD : `LCM_RAM_BASE_NEW;
        if (acc.rd || acc.wr) begin
            if (acc.io_instr) begin
                // [R03] short I/O stays below 64
                // [R02] direct legacy I/O index
                if (acc.addr < `LCM_IO_COUNT) begin
                    s.io      = 1'b1;
                    s.io_addr = acc.addr[5:0];
                end
            end else if (acc.addr >= `LCM_DS_IO_BASE &&
                         acc.addr < `LCM_DS_IO_BASE + `LCM_IO_COUNT) begin
                // [R02] same I/O through data space
                s.io      = 1'b1;
                s.io_addr = 6'(acc.addr - `LCM_DS_IO_BASE);
            end else if (!old_map && acc.addr >= `LCM_EXT_IO_BASE &&
                         acc.addr <= `LCM_EXT_IO_LAST) begin
                // [R01] extended I/O window
                s.ext_io = 1'b1;
            end else if (acc.addr >= ram_base) begin
                // [R04] RAM base follows mode
                s.ram     = 1'b1;
                s.ram_off = acc.addr - ram_base;
            end
        end
        return s;
    endfunction : decode

    assign next_sel = decode(cpu_acc, compat);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cpu_sel <= '0;
        end else begin
            cpu_sel <= next_sel;
        end
    end

    // ----------------------------------------
    // Feature request register
    // ----------------------------------------
    // Unused upper data bits are ignored; software is expected to keep them zero.
    // [R19] upper bits ignored
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            feat_req <= `LCM_FEAT_RESET;
        end else if (reg_wr && reg_addr == `LCM_REG_FEAT_REQ) begin
            feat_req <= reg_wdata[`LCM_FEAT_WIDTH-1:0];
        end
    end

    // [R07] second timer and third compare gone
    // [R08] two-wire off
    // [R12] boot loader off
    // [R06] second USART off
    assign feat_eff = compat ? '0 : feat_req;

    // ----------------------------------------
    // Unit enables
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            unit_en <= '0;
        end else begin
            unit_en.usart1 <= feat_eff[`LCM_FEAT_USART1];
            unit_en.timer3 <= feat_eff[`LCM_FEAT_TIMER3];
            unit_en.ocr_c  <= feat_eff[`LCM_FEAT_OCRC];
            unit_en.twi    <= feat_eff[`LCM_FEAT_TWI];
            unit_en.boot   <= feat_eff[`LCM_FEAT_BOOT];
            // [R04] extended functions idle
            unit_en.ext_io <= !compat;
        end
    end

    // ----------------------------------------
    // USART and interrupt gating
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            periph_ctl.usart_sync   <= 1'b0;
            periph_ctl.baud_div     <= '0;
            periph_ctl.rx_buf_depth <= `LCM_RXBUF_COMPAT;
            periph_ctl.ext_vectors  <= 1'b0;
            periph_ctl.int_sense    <= `LCM_SENSE_LEVEL;
        end else begin
            // [R06] async only, low baud bits
            periph_ctl.usart_sync   <= compat ? 1'b0 : periph_req.usart_sync;
            periph_ctl.baud_div     <= compat ? (periph_req.baud_div & `LCM_BAUD_LOW_MASK)
                                              : periph_req.baud_div;
            // [R18] single receive buffer
            periph_ctl.rx_buf_depth <= compat ? `LCM_RXBUF_COMPAT : `LCM_RXBUF_NATIVE;
            // [R05] old vector table
            periph_ctl.ext_vectors  <= !compat;
            // [R17] level sense only
            periph_ctl.int_sense    <= compat ? `LCM_SENSE_LEVEL : periph_req.int_sense;
        end
    end

    // ----------------------------------------
    // Port gating
    // ----------------------------------------
    // Port C drives out as soon as reset ends in compat mode, since the old
    // part had no input stage there.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            periph_ctl.portc_dir   <= '0;
            periph_ctl.portc_in_en <= 1'b0;
            periph_ctl.portf_dir   <= '0;
            periph_ctl.portg_gpio  <= 1'b0;
        end else begin
            // [R09] port C output only
            periph_ctl.portc_dir   <= compat ? `LCM_PORTC_ALL_OUT : periph_req.portc_dir;
            periph_ctl.portc_in_en <= !compat;
            // [R11] port F input only
            periph_ctl.portf_dir   <= compat ? `LCM_PORTF_ALL_IN : periph_req.portf_dir;
            // [R10] port G alternate only
            periph_ctl.portg_gpio  <= compat ? 1'b0 : periph_req.portg_gpio;
        end
    end

    // ----------------------------------------
    // System control gating
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            periph_ctl.trim_wr                <= 1'b0;
            periph_ctl.wdt_chg                <= 1'b0;
            periph_ctl.mcu_control_status_reg <= '0;
            periph_ctl.ws_split               <= 1'b0;
            periph_ctl.xmem_release           <= '0;
        end else begin
            // [R13] trim write blocked
            periph_ctl.trim_wr <= compat ? 1'b0 : periph_req.trim_wr;
            // [R16] no timed unlock
            periph_ctl.wdt_chg <= periph_req.wdt_chg && (compat || periph_req.wdt_unlock);
            // [R15] only reset pin and power-on flags
            periph_ctl.mcu_control_status_reg <= compat
                ? (periph_req.rst_cause & `LCM_RSTF_KEEP) : periph_req.rst_cause;
            // [R14] no pin release, one wait state set
            periph_ctl.ws_split     <= compat ? 1'b0 : periph_req.ws_split;
            periph_ctl.xmem_release <= compat ? 3'h0 : periph_req.xmem_release;
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `LCM_REG_MODE: begin
                    reg_rdata <= {6'h00, (mode != LCM_ST_WAIT), compat};
                end
                `LCM_REG_FEAT_REQ: begin
                    reg_rdata <= {3'h0, feat_req};
                end
                `LCM_REG_FEAT_EFF: begin
                    reg_rdata <= {3'h0, feat_eff};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : lcm_gate

// [tb/lcm_gate_chk.sv]
// Checker for the legacy mode gating block, bound to lcm_gate.
// Assumes the fuse only changes while reset is held.
`timescale 1ns/1ps

module lcm_gate_chk
    import lcm_pkg::*;
(
    // Clock and reset
    input wire logic         mclk,
    input wire logic         rstn,
    // Watched ports
    input wire logic         legacy_compat_fuse,
    input wire lcm_acc_t     cpu_acc,
    input wire lcm_sel_t     cpu_sel,
    input wire lcm_req_t     periph_req,
    input wire lcm_ctl_t     periph_ctl,
    input wire lcm_unit_en_t unit_en
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Mode is trusted only once the fuse latch has settled
    logic [1:0] age;
    logic       warm;
    logic       cpt;
    logic       acc;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    assign warm = age[1];
    assign cpt  = warm && legacy_compat_fuse;
    assign acc  = cpu_acc.rd || cpu_acc.wr;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_ext_dec;
        warm && cpu_sel.ext_io |-> !legacy_compat_fuse && !$past(cpu_acc.io_instr)
            && $past(cpu_acc.addr) inside {[16'h0060:16'h00FF]};
    endproperty
    a_ext_dec: assert property (p_ext_dec) else $error("ext io decode wrong");
    property p_io_keep;
        acc && !cpu_acc.io_instr && cpu_acc.addr inside {[16'h0020:16'h005F]} ##1 warm
        |-> cpu_sel.io && cpu_sel.io_addr == $past(cpu_acc.addr[5:0]) - 6'h20;
    endproperty
    a_io_keep: assert property (p_io_keep) else $error("legacy io address moved");
    property p_ram_old;
        acc && !cpu_acc.io_instr && cpu_acc.addr inside {[16'h0060:16'h00FF]} ##1 cpt
        |-> cpu_sel.ram && cpu_sel.ram_off == $past(cpu_acc.addr) - 16'h0060;
    endproperty
    a_ram_old: assert property (p_ram_old) else $error("compat ram not at old base");
    property p_vect;
        cpt |-> !periph_ctl.ext_vectors;
    endproperty
    a_vect: assert property (p_vect) else $error("extended vectors in compat");
    property p_usart;
        cpt |-> !periph_ctl.usart_sync && periph_ctl.rx_buf_depth == 2'h1
            && periph_ctl.baud_div == ($past(periph_req.baud_div) & 12'h0FF);
    endproperty
    a_usart: assert property (p_usart) else $error("compat usart gating wrong");
    property p_units;
        cpt |-> unit_en == 6'h00;
    endproperty
    a_units: assert property (p_units) else $error("unit enabled in compat");
    property p_ports;
        cpt |-> periph_ctl.portc_dir == 8'hFF && !periph_ctl.portc_in_en
            && periph_ctl.portf_dir == 8'h00 && !periph_ctl.portg_gpio;
    endproperty
    a_ports: assert property (p_ports) else $error("compat port gating");
    property p_misc;
        cpt |-> !periph_ctl.trim_wr && !periph_ctl.ws_split
            && periph_ctl.xmem_release == 3'h0 && periph_ctl.int_sense == 8'h00;
    endproperty
    a_misc: assert property (p_misc) else $error("compat misc gating wrong");
    property p_rstf;
        cpt |-> periph_ctl.mcu_control_status_reg == ($past(periph_req.rst_cause) & 5'h03)
            && periph_ctl.wdt_chg == $past(periph_req.wdt_chg);
    endproperty
    a_rstf: assert property (p_rstf) else $error("compat flags or watchdog wrong");
    property p_native;
        warm && !legacy_compat_fuse |-> periph_ctl.rx_buf_depth == 2'h2
            && periph_ctl.baud_div == $past(periph_req.baud_div);
    endproperty
    a_native: assert property (p_native) else $error("native mode not passed through");

    c_ext: cover property (warm && cpu_sel.ext_io);
    c_ram: cover property (cpt && cpu_sel.ram);
    c_io: cover property (warm && cpu_sel.io);
endmodule : lcm_gate_chk

bind lcm_gate lcm_gate_chk lcm_gate_chk_inst (
    .mclk(mclk), .rstn(rstn), .legacy_compat_fuse(legacy_compat_fuse),
    .cpu_acc(cpu_acc), .cpu_sel(cpu_sel), .periph_req(periph_req),
    .periph_ctl(periph_ctl), .unit_en(unit_en));

// [tb/lcm_gate_tb.sv]
// Self-checking bench for the legacy mode gating block.
// Assumes lcm_pkg and the checker are compiled first; no partner model.
`timescale 1ns/1ps

module lcm_gate_tb
    import lcm_pkg::*;
;
    logic         mclk = 1'b0;
    logic         rstn = 1'b0;
    logic         fuse = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [7:0]   reg_rdata;
    lcm_acc_t     cpu_acc = '0;
    lcm_sel_t     cpu_sel;
    // Every request field but wdt_unlock set so that gating shows
    lcm_req_t     req = {1'b1, 12'hABC, 8'h0F, 8'hF0, 1'b1, 8'h55, 1'b1, 1'b1, 1'b0,
                         5'h1F, 1'b1, 3'h5};
    lcm_ctl_t     ctl;
    lcm_unit_en_t unit_en;
    int           n_mismatch = 0;
    int           comparisons = 0;
    int           cycles = 0;

    always #5 mclk = ~mclk;

    lcm_gate lcm_gate_inst (
        .mclk(mclk), .rstn(rstn), .legacy_compat_fuse(fuse), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_acc(cpu_acc), .cpu_sel(cpu_sel), .periph_req(req), .periph_ctl(ctl),
        .unit_en(unit_en));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        comparisons++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic start(input logic f);
        @(posedge mclk);
        rstn <= 1'b0;
        fuse <= f;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : start

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand one cycle only, then fall back to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(64'(reg_rdata), 64'(want));
        @(posedge mclk);
        #1 check(64'(reg_rdata), 64'h0);
    endtask : rd

    function automatic lcm_sel_t sl(logic i, logic e, logic r, logic [5:0] ia,
                                    logic [15:0] off);
        return {i, e, r, ia, off};
    endfunction : sl

    task automatic cpu(input logic [15:0] a, input logic io, input lcm_sel_t want);
        @(posedge mclk);
        cpu_acc <= {a, 1'b1, 1'b0, io};
        @(posedge mclk);
        #1 check(64'(cpu_sel), 64'(want));
    endtask : cpu

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        start(1'b0);
        rd(8'h00, 8'h02);
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h02);
        check(64'(unit_en), 64'h3F);
        wr(8'h01, 8'h0A);
        rd(8'h01, 8'h0A);
        rd(8'h02, 8'h0A);
        rd(8'h33, 8'h00);
        check(64'(unit_en), 64'h15);
        cpu(16'h0080, 1'b0, sl(1'b0, 1'b1, 1'b0, 6'h00, 16'h0000));
        cpu(16'h00FF, 1'b0, sl(1'b0, 1'b1, 1'b0, 6'h00, 16'h0000));
        cpu(16'h0025, 1'b0, sl(1'b1, 1'b0, 1'b0, 6'h05, 16'h0000));
        cpu(16'h003F, 1'b1, sl(1'b1, 1'b0, 1'b0, 6'h3F, 16'h0000));
        cpu(16'h0050, 1'b1, sl(1'b0, 1'b0, 1'b0, 6'h00, 16'h0000));
        cpu(16'h0100, 1'b0, sl(1'b0, 1'b0, 1'b1, 6'h00, 16'h0000));
        cpu(16'h0010, 1'b0, sl(1'b0, 1'b0, 1'b0, 6'h00, 16'h0000));
        check(64'(ctl), 64'({1'b1, 12'hABC, 8'h0F, 1'b1, 8'hF0, 1'b1, 8'h55, 1'b1, 1'b0,
                             5'h1F, 1'b1, 3'h5, 2'h2, 1'b1}));
        // Native watchdog change goes through only with the unlock
        @(posedge mclk);
        req.wdt_unlock <= 1'b1;
        @(posedge mclk);
        #1 check(64'(ctl.wdt_chg), 64'h1);
        @(posedge mclk);
        req.wdt_unlock <= 1'b0;
        $display("test native done");
        start(1'b1);
        rd(8'h00, 8'h03);
        rd(8'h01, 8'h1F);
        rd(8'h02, 8'h00);
        check(64'(unit_en), 64'h00);
        cpu(16'h0080, 1'b0, sl(1'b0, 1'b0, 1'b1, 6'h00, 16'h0020));
        cpu(16'h0060, 1'b0, sl(1'b0, 1'b0, 1'b1, 6'h00, 16'h0000));
        cpu(16'h00FF, 1'b0, sl(1'b0, 1'b0, 1'b1, 6'h00, 16'h009F));
        cpu(16'h0100, 1'b0, sl(1'b0, 1'b0, 1'b1, 6'h00, 16'h00A0));
        cpu(16'h005F, 1'b0, sl(1'b1, 1'b0, 1'b0, 6'h3F, 16'h0000));
        cpu(16'h0060, 1'b1, sl(1'b0, 1'b0, 1'b0, 6'h00, 16'h0000));
        check(64'(ctl), 64'({1'b0, 12'h0BC, 8'hFF, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1,
                             5'h03, 1'b0, 3'h0, 2'h1, 1'b0}));
        @(posedge mclk);
        req.baud_div <= 12'h3FF;
        @(posedge mclk);
        #1 check(64'(ctl.baud_div), 64'h0FF);
        $display("test compat done");
        final_report();
    end
endmodule : lcm_gate_tb
